// File: ebwc_top.sv
// External bus write-control block with Wishbone register access
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
module ebwc_top #(
  parameter int ADDR_W = 20,
  parameter int CS_W = 3,
  parameter bit MULT_SELECTABLE = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core-side access request
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_word_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [CS_W-1:0] req_cs_i,
  input wire logic [15:0] req_wdata_i,
  output logic done_o,
  output logic error_o,
  output logic [15:0] rdata_o,
  // External memory pins
  output logic [ADDR_W-1:0] addr_o,
  output logic [CS_W-1:0] chip_select_out_n_o,
  output logic rd_n_o,
  output logic low_byte_write_strobe_n_o,
  output logic high_byte_enable_n_o,
  output logic [15:0] data_o,
  output logic data_oe_o,
  input wire logic [15:0] data_i,
  output logic clock_output_o
);
  initial begin
    if (ADDR_W < 2 || ADDR_W > 24) begin
      $error("ebwc_top: ADDR_W out of range");
    end
    if (CS_W < 1 || CS_W > 4) begin
      $error("ebwc_top: CS_W out of range");
    end
  end

  localparam logic [1:0] DEFER_LAST = 2'(ebwc_pkg::DEFER_CYC - 1);
  localparam logic [1:0] STROBE_LAST = 2'(ebwc_pkg::STROBE_CYC - 1);

  function automatic logic [CS_W-1:0] cs_onehot_n(input logic [CS_W-1:0] c);
    logic [CS_W-1:0] r;
    r = '1;
    r[c[$clog2(CS_W+1)-1:0] % CS_W] = 1'b0;
    return r;
  endfunction : cs_onehot_n

  function automatic logic mult_legal(input logic [1:0] code);
    if (!MULT_SELECTABLE) begin
      return code == ebwc_pkg::MULT_X1;
    end
    return code != 2'h3;
  endfunction : mult_legal

  // Control register fields and the sticky illegal-access flag
  logic bus16_q;
  logic wmode_q;
  logic defer_q;
  logic [1:0] mult_q;
  logic ill_q;
  // Bus sequencer state
  ebwc_pkg::ebwc_state_e state_q;
  ebwc_pkg::ebwc_state_e state_d;
  logic [1:0] cnt_q;
  logic cur_write_q;
  logic cur_word_q;
  logic cur_a0_q;
  logic [CS_W-1:0] cur_cs_q;
  logic [CS_W-1:0] last_cs_q;
  logic cs_valid_q;
  logic last_read_q;
  logic [15:0] sync1_q;
  logic [15:0] sync2_q;
  logic need_defer;
  logic idle_now;
  logic take;
  logic req_illegal;
  logic wb_req;
  logic wb_wr;
  logic ill_set;
  logic ill_clr;

  ebwc_dec_if dif ();

  ebwc_strobe_dec u_dec (
    .d(dif)
  );

  assign dif.std_mode = wmode_q;
  assign dif.bus16 = bus16_q;
  // Decoder sees the coming state so pins line up with chip select
  assign idle_now = state_q == ebwc_pkg::ST_IDLE;
  assign dif.word = idle_now ? req_word_i : cur_word_q;
  assign dif.a0 = idle_now ? req_addr_i[0] : cur_a0_q;
  assign dif.write = idle_now ? req_write_i : cur_write_q;
  assign dif.active = (state_d == ebwc_pkg::ST_ADDR) |
                      (state_d == ebwc_pkg::ST_STRB) |
                      (state_d == ebwc_pkg::ST_HOLD);
  assign dif.strobe = state_d == ebwc_pkg::ST_STRB;

  // Wishbone decode
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;

  // Request acceptance and refusal
  assign take = req_i & ~done_o & (state_q == ebwc_pkg::ST_IDLE);
  assign req_illegal = req_word_i & req_addr_i[0];
  assign need_defer = defer_q & cs_valid_q &
                      ((req_cs_i != last_cs_q) |
                       (req_write_i & last_read_q));

  // Wishbone acknowledge, one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus16_q <= ebwc_pkg::RST_BUS16;
      wmode_q <= ebwc_pkg::RST_WMODE;
      defer_q <= ebwc_pkg::RST_DEFER;
      mult_q <= ebwc_pkg::MULT_X1;
    end else if (wb_wr && wb_adr_i == ebwc_pkg::CTRL_OFS) begin
      if (wb_sel_i[0]) begin
        bus16_q <= wb_dat_i[ebwc_pkg::CTRL_BUS16_BIT];
        wmode_q <= wb_dat_i[ebwc_pkg::CTRL_WMODE_BIT];
        defer_q <= wb_dat_i[ebwc_pkg::CTRL_DEFER_BIT];
      end
      // Unsupported multiplier codes keep the old setting
      if (wb_sel_i[1] &&
          mult_legal(wb_dat_i[ebwc_pkg::CTRL_MULT_LSB +: 2])) begin
        mult_q <= wb_dat_i[ebwc_pkg::CTRL_MULT_LSB +: 2];
      end
    end
  end

  // Sticky illegal-access flag, set beats write-one clear
  assign ill_set = take & req_illegal;
  assign ill_clr = wb_wr & (wb_adr_i == ebwc_pkg::STAT_OFS) & wb_sel_i[0] &
                   wb_dat_i[ebwc_pkg::STAT_ILL_BIT];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ill_q <= 1'b0;
    end else if (ill_set) begin
      ill_q <= 1'b1;
    end else if (ill_clr) begin
      ill_q <= 1'b0;
    end
  end

  // Register read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= 32'h0000_0000;
      case (wb_adr_i)
        ebwc_pkg::CTRL_OFS: begin
          wb_dat_o[ebwc_pkg::CTRL_BUS16_BIT] <= bus16_q;
          wb_dat_o[ebwc_pkg::CTRL_WMODE_BIT] <= wmode_q;
          wb_dat_o[ebwc_pkg::CTRL_DEFER_BIT] <= defer_q;
          wb_dat_o[ebwc_pkg::CTRL_MULT_LSB +: 2] <= mult_q;
        end
        ebwc_pkg::STAT_OFS: begin
          wb_dat_o[ebwc_pkg::STAT_BUSY_BIT] <=
            state_q != ebwc_pkg::ST_IDLE;
          wb_dat_o[ebwc_pkg::STAT_ILL_BIT] <= ill_q;
          wb_dat_o[ebwc_pkg::STAT_LASTRD_BIT] <= last_read_q;
          wb_dat_o[ebwc_pkg::STAT_CS_LSB +: CS_W] <= last_cs_q;
        end
        default: begin
          wb_dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ebwc_pkg::ST_IDLE: begin
        if (take && !req_illegal) begin
          state_d = need_defer ? ebwc_pkg::ST_DEFER : ebwc_pkg::ST_ADDR;
        end
      end
      ebwc_pkg::ST_DEFER: begin
        if (cnt_q == DEFER_LAST) begin
          state_d = ebwc_pkg::ST_ADDR;
        end
      end
      ebwc_pkg::ST_ADDR: begin
        state_d = ebwc_pkg::ST_STRB;
      end
      ebwc_pkg::ST_STRB: begin
        if (cnt_q == STROBE_LAST) begin
          state_d = ebwc_pkg::ST_HOLD;
        end
      end
      ebwc_pkg::ST_HOLD: begin
        state_d = ebwc_pkg::ST_IDLE;
      end
      default: begin
        state_d = ebwc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ebwc_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Period counter for deferral and strobe width
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
    end else if (state_d != state_q) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  // Latch the accepted request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_write_q <= 1'b0;
      cur_word_q <= 1'b0;
      cur_a0_q <= 1'b0;
      cur_cs_q <= '0;
      addr_o <= '0;
      data_o <= 16'h0000;
    end else if (take && !req_illegal) begin
      cur_write_q <= req_write_i;
      cur_word_q <= req_word_i;
      cur_a0_q <= req_addr_i[0];
      cur_cs_q <= req_cs_i;
      addr_o <= req_addr_i;
      data_o <= req_wdata_i;
    end
  end

  // History for deferred-cycle decisions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_cs_q <= '0;
      cs_valid_q <= 1'b0;
      last_read_q <= 1'b0;
    end else if (state_q == ebwc_pkg::ST_HOLD) begin
      last_cs_q <= cur_cs_q;
      cs_valid_q <= 1'b1;
      last_read_q <= ~cur_write_q;
    end
  end

  // Chip select, read strobe and data drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chip_select_out_n_o <= '1;
      rd_n_o <= 1'b1;
      data_oe_o <= 1'b0;
    end else begin
      chip_select_out_n_o <= (state_d == ebwc_pkg::ST_IDLE) ? '1 :
        cs_onehot_n(state_q == ebwc_pkg::ST_IDLE ? req_cs_i : cur_cs_q);
      rd_n_o <= ~(state_d == ebwc_pkg::ST_STRB && !cur_write_q);
      data_oe_o <= cur_write_q & ((state_d == ebwc_pkg::ST_STRB) |
                                  (state_d == ebwc_pkg::ST_HOLD));
    end
  end

  // Write-control pins, high outside bus cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_byte_write_strobe_n_o <= 1'b1;
      high_byte_enable_n_o <= 1'b1;
    end else begin
      low_byte_write_strobe_n_o <= dif.pin_lo_n;
      high_byte_enable_n_o <= dif.pin_hi_n;
    end
  end

  // Read data synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
    end else begin
      sync1_q <= data_i;
      sync2_q <= sync1_q;
    end
  end

  // Completion and read data selection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      error_o <= 1'b0;
      rdata_o <= 16'h0000;
    end else begin
      done_o <= (state_q == ebwc_pkg::ST_HOLD) | ill_set;
      error_o <= ill_set;
      if (state_q == ebwc_pkg::ST_HOLD && !cur_write_q) begin
        if (cur_word_q) begin
          rdata_o <= sync2_q;
        end else if (bus16_q && cur_a0_q) begin
          rdata_o <= {8'h00, sync2_q[15:8]};
        end else begin
          rdata_o <= {8'h00, sync2_q[7:0]};
        end
      end
    end
  end

  // Clock output at half the operating rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_output_o <= 1'b0;
    end else begin
      clock_output_o <= ~clock_output_o;
    end
  end
endmodule : ebwc_top

// File: ebwc_pkg.sv
// Constants and types of the external bus write-control block
package ebwc_pkg;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  // Control field positions
  localparam int CTRL_BUS16_BIT = 0;
  localparam int CTRL_WMODE_BIT = 2;
  localparam int CTRL_DEFER_BIT = 5;
  localparam int CTRL_MULT_LSB = 8;
  // Status field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ILL_BIT = 1;
  localparam int STAT_LASTRD_BIT = 2;
  localparam int STAT_CS_LSB = 4;
  // Reset values
  localparam logic RST_BUS16 = 1'b1;
  localparam logic RST_WMODE = 1'b1;
  localparam logic RST_DEFER = 1'b0;
  // Clock multiplier codes
  localparam logic [1:0] MULT_X1 = 2'h0;
  localparam logic [1:0] MULT_X2 = 2'h1;
  localparam logic [1:0] MULT_X4 = 2'h2;
  // Timing: one operating period equals one clk_i cycle (40 ns)
  localparam int CLK_PERIOD_NS = 40;
  localparam int DEFER_NS = 80;
  localparam int STROBE_NS = 80;
  localparam int DEFER_CYC = (DEFER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Bus cycle states, Gray from ST_IDLE through ST_DEFER to ST_HOLD
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEFER = 3'h1,
    ST_ADDR = 3'h3,
    ST_STRB = 3'h2,
    ST_HOLD = 3'h6
  } ebwc_state_e;
endpackage : ebwc_pkg

// File: ebwc_dec_if.sv
// Carrier between the bus sequencer and the strobe decoder
`timescale 1ns/100ps
interface ebwc_dec_if;
  logic std_mode;
  logic bus16;
  logic word;
  logic a0;
  logic write;
  logic active;
  logic strobe;
  logic pin_lo_n;
  logic pin_hi_n;
  logic illegal;
  modport seq (output std_mode, bus16, word, a0, write, active, strobe,
               input pin_lo_n, pin_hi_n, illegal);
  modport dec (input std_mode, bus16, word, a0, write, active, strobe,
               output pin_lo_n, pin_hi_n, illegal);
endinterface : ebwc_dec_if

// File: ebwc_strobe_dec.sv
// Write-control pin decoder for both write-control modes
`timescale 1ns/100ps
module ebwc_strobe_dec (
  ebwc_dec_if.dec d
);
  logic wr_pulse;
  assign d.illegal = d.word & d.a0;
  assign wr_pulse = d.active & d.write & d.strobe & ~d.illegal;
  always_comb begin
    if (d.std_mode) begin
      // Shared pins act as write strobe and high-byte enable
      d.pin_lo_n = ~wr_pulse;
      d.pin_hi_n = ~(d.active & ~d.illegal & (d.word | d.a0));
    end else if (d.bus16) begin
      d.pin_lo_n = ~(wr_pulse & (d.word | ~d.a0));
      d.pin_hi_n = ~(wr_pulse & (d.word | d.a0));
    end else begin
      d.pin_lo_n = ~wr_pulse;
      d.pin_hi_n = ~wr_pulse;
    end
  end
endmodule : ebwc_strobe_dec

// File: ebwc_props.sv
// Port checks for the write-control block
`timescale 1ns/100ps
module ebwc_props #(
  parameter int ADDR_W = 20,
  parameter int CS_W = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Core request
  input wire logic req_i,
  input wire logic req_word_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic done_o,
  input wire logic error_o,
  // Pins
  input wire logic [CS_W-1:0] chip_select_out_n_o,
  input wire logic rd_n_o,
  input wire logic low_byte_write_strobe_n_o,
  input wire logic high_byte_enable_n_o,
  input wire logic data_oe_o,
  input wire logic clock_output_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_pulse2(x);
    !x ##1 !x ##1 x;
  endsequence
  sequence s_bad_take;
    $rose(req_i) && req_word_i && req_addr_i[0];
  endsequence
  a_ack_single: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o)
    |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing wrong");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_err_quiet: assert property (error_o |-> done_o && rd_n_o &&
    low_byte_write_strobe_n_o && high_byte_enable_n_o
    && (&chip_select_out_n_o)) else $error("refused access moved pins");
  a_bad_refused: assert property (s_bad_take |-> ##[1:2] error_o)
    else $error("odd word not refused");
  a_legal_done: assert property ($rose(req_i) && !(req_word_i &&
    req_addr_i[0]) |-> ##[4:9] done_o) else $error("access not done");
  a_strobe_pulse: assert property ($fell(low_byte_write_strobe_n_o)
    |-> s_pulse2(low_byte_write_strobe_n_o)) else $error("bad strobe");
  a_no_wr_read: assert property (!rd_n_o |-> low_byte_write_strobe_n_o)
    else $error("write strobe in read");
  a_idle_high: assert property ((&chip_select_out_n_o) |-> rd_n_o &&
    low_byte_write_strobe_n_o && high_byte_enable_n_o)
    else $error("pin active outside cycle");
  a_clk_half: assert property (1 |=> $changed(clock_output_o))
    else $error("clock output not toggling");
  a_drive_write: assert property (!low_byte_write_strobe_n_o
    |-> data_oe_o) else $error("write strobe without data drive");
  a_read_float: assert property (!rd_n_o |-> !data_oe_o)
    else $error("data driven during read");
endmodule : ebwc_props

bind ebwc_top ebwc_props #(.ADDR_W(ADDR_W), .CS_W(CS_W)) i_props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .req_i, .req_word_i,
  .req_addr_i, .done_o, .error_o, .chip_select_out_n_o, .rd_n_o,
  .low_byte_write_strobe_n_o, .high_byte_enable_n_o, .clock_output_o,
  .data_oe_o
);

// File: ebwc_mem_model.sv
// External 16-bit memory behind the write-control pins
`timescale 1ns/100ps
module ebwc_mem_model (
  // Clock and pin wiring
  input wire logic clk_i,
  input wire logic std_mode_i,
  // Memory pins
  input wire logic [19:0] addr_i,
  input wire logic [2:0] cs_n_i,
  input wire logic rd_n_i,
  input wire logic lo_n_i,
  input wire logic hi_n_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o
);
  logic [15:0] mem_q [256];
  logic [15:0] last_q = 16'hA5A5;
  logic sel;
  logic [7:0] idx;
  assign sel = cs_n_i != 3'h7;
  assign idx = addr_i[8:1];
  // Both bytes on a read; bus churns when released
  assign data_o = (sel && !rd_n_i) ? mem_q[idx] : ~last_q;
  always @(posedge clk_i) begin
    last_q <= data_o;
    if (sel && !lo_n_i && (!std_mode_i || !addr_i[0]))
      mem_q[idx][7:0] <= data_i[7:0];
    if (sel && !hi_n_i && (!std_mode_i || !lo_n_i))
      mem_q[idx][15:8] <= data_i[15:8];
  end
endmodule : ebwc_mem_model

// File: ebwc_top_test.sv
// Testbench for the write-control block with a memory model
`timescale 1ns/100ps
module ebwc_top_test;
  logic clk_i = 1'b0, rst_i = 1'b1, std_mode = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic req_i = 1'b0, req_write_i = 1'b0, req_word_i = 1'b0;
  logic [19:0] req_addr_i = 20'h0, addr_o;
  logic [2:0] req_cs_i = 3'h0, chip_select_out_n_o;
  logic [15:0] req_wdata_i = 16'h0, rdata_o, data_o, data_i;
  logic done_o, error_o, rd_n_o, low_byte_write_strobe_n_o;
  logic high_byte_enable_n_o, data_oe_o, clock_output_o;
  logic lo_seen = 1'b0, hi_seen = 1'b0;
  int failures = 0, check_count = 0;
  always #20 clk_i = ~clk_i;
  ebwc_top i_dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .req_i, .req_write_i, .req_word_i,
    .req_addr_i, .req_cs_i, .req_wdata_i, .done_o, .error_o, .rdata_o,
    .addr_o, .chip_select_out_n_o, .rd_n_o, .low_byte_write_strobe_n_o,
    .high_byte_enable_n_o, .data_o, .data_oe_o, .data_i, .clock_output_o
  );
  ebwc_mem_model i_mem (
    .clk_i, .std_mode_i(std_mode), .addr_i(addr_o),
    .cs_n_i(chip_select_out_n_o), .rd_n_i(rd_n_o),
    .lo_n_i(low_byte_write_strobe_n_o), .hi_n_i(high_byte_enable_n_o),
    .data_i(data_o), .data_o(data_i)
  );
  // Strobe activity seen during the current request
  always @(posedge clk_i) begin
    lo_seen <= req_i && (lo_seen || !low_byte_write_strobe_n_o);
    hi_seen <= req_i && (hi_seen || !high_byte_enable_n_o);
  end
  task complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task wb(input logic we, input logic [3:0] a, input logic [31:0] d,
          output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      complete_run();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task access(input logic w, input logic wd, input logic [19:0] a,
              input logic [2:0] cs, input logic [15:0] d, output int n,
              output logic lo, output logic hi, output logic er);
    @(posedge clk_i);
    req_i <= 1'b1;
    req_write_i <= w;
    req_word_i <= wd;
    req_addr_i <= a;
    req_cs_i <= cs;
    req_wdata_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      complete_run();
    end
    lo = lo_seen;
    hi = hi_seen;
    er = error_o;
    req_i <= 1'b0;
  endtask : access
  initial begin
    logic [31:0] q;
    logic [19:0] a;
    logic lo, hi, er, w, wd, elo, ehi;
    int n, base;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 4'h0, 0, q);
    check(q, 32'h5);
    wb(1, 4'h0, 32'h205, q);
    wb(0, 4'h0, 0, q);
    check(q, 32'h205);
    wb(1, 4'h0, 32'h305, q);
    wb(0, 4'h0, 0, q);
    check(q, 32'h205);
    wb(0, 4'h8, 0, q);
    check(q, 32'h0);
    for (int m = 0; m < 3; m++) begin
      wb(1, 4'h0, (m == 0) ? 32'h5 : (m == 1) ? 32'h1 : 32'h0, q);
      std_mode <= (m == 0);
      for (int k = 0; k < 6; k++) begin
        w = k < 3;
        wd = k % 3 == 2;
        a = 20'h10 | 20'((k % 3) == 1);
        access(w, wd, a, 3'h0, 16'hC3C3, n, lo, hi, er);
        elo = w && (m != 1 || wd || !a[0]);
        ehi = (m == 0) ? wd || a[0] : w && (m == 2 || wd || a[0]);
        check(32'(lo), 32'(elo));
        check(32'(hi), 32'(ehi));
      end
    end
    wb(1, 4'h0, 32'h5, q);
    std_mode <= 1'b1;
    access(1, 1, 20'h40, 3'h0, 16'h1234, base, lo, hi, er);
    access(1, 0, 20'h41, 3'h0, 16'h5656, n, lo, hi, er);
    access(0, 1, 20'h40, 3'h0, 16'h0, n, lo, hi, er);
    check(32'(rdata_o), 32'h5634);
    access(0, 0, 20'h41, 3'h0, 16'h0, n, lo, hi, er);
    check(32'(rdata_o[7:0]), 32'h56);
    wb(1, 4'h0, 32'h1, q);
    std_mode <= 1'b0;
    access(1, 0, 20'h40, 3'h0, 16'h7878, n, lo, hi, er);
    access(0, 1, 20'h40, 3'h0, 16'h0, n, lo, hi, er);
    check(32'(rdata_o), 32'h5678);
    access(1, 1, 20'h43, 3'h0, 16'h0, n, lo, hi, er);
    check(32'({er, lo, hi}), 32'h4);
    wb(0, 4'h4, 0, q);
    check(32'(q[1]), 32'h1);
    wb(1, 4'h4, 32'h2, q);
    wb(0, 4'h4, 0, q);
    check(32'(q[1]), 32'h0);
    access(1, 1, 20'h50, 3'h0, 16'h0, n, lo, hi, er);
    wb(1, 4'h0, 32'h25, q);
    std_mode <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      access(k != 3 && k != 5, 1, 20'h50, (k == 0) ? 3'h0 : (k == 5) ?
             3'h2 : 3'h1, 16'h0, n, lo, hi, er);
      check(32'(n), 32'(base + ((k == 1 || k > 3) ? 2 : 0)));
    end
    complete_run();
  end
endmodule : ebwc_top_test
